// >>> pkg/radio_cfg_defs.svh
// register offsets, field positions, reset values and timing constants
`ifndef RADIO_CFG_DEFS_SVH
`define RADIO_CFG_DEFS_SVH
// register offsets (5-bit serial address)
`define OFS_PIPE_EN      5'h02
`define OFS_ADDR_WIDTH   5'h03
`define OFS_RETR_SETUP   5'h04
`define OFS_CHANNEL      5'h05
`define OFS_RADIO_SETUP  5'h06
// serial command codes in command bits 7:5
`define CMD_READ         3'h0
`define CMD_WRITE        3'h1
// field positions
`define RETR_DELAY_LSB   4
`define RADIO_PLL_BIT    4
`define RADIO_RATE_BIT   3
`define RADIO_PWR_LSB    1
// reset values
`define RST_PIPE_EN      5'h03
`define RST_ADDR_WIDTH   2'h3
`define RST_RETR_DELAY   4'h0
`define RST_RETR_COUNT   4'h3
`define RST_CHANNEL      7'h02
`define RST_PLL_FORCE    1'b0
`define RST_AIR_RATE     1'b1
`define RST_POWER        2'h3
// retransmit delay step and clock rate
`define RETR_STEP_US     250
`define CLK_FREQ_MHZ     10
`endif

// >>> pkg/radio_cfg_pkg.sv
// types shared by the radio configuration register slice
package radio_cfg_pkg;
    // settings seen by the packet engine and radio
    typedef struct packed {
        logic [4:0] receive_pipe_enables;
        logic [1:0] address_width_code;
        logic [3:0] retransmit_delay_code;
        logic [3:0] retransmit_count_limit;
        logic [6:0] channel_number;
        logic       pll_lock_force;
        logic       air_rate_select;
        logic [1:0] output_power_code;
    } radio_cfg_t;
    typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_DONE} spi_phase_t;
    typedef enum logic {RT_IDLE, RT_WAIT} retr_state_t;
endpackage

// >>> rtl/radio_link_config_registers.sv
// serial-port configuration registers with retransmit delay and count control
//
// Summary of operation
// - width code 01/10/11 means 3/4/5 bytes; 00 illegal; resets to 11.
// - short widths use the low address bytes, upper bytes ignored.
// - delay code in bits 7:4 waits 250 us times code plus one.
// - delay runs from end of one transmission to start of the next.
// - count 0 disables retransmit; N allows up to N retries, max 15.
// - channel number in bits 6:0, resets to 2, bit 7 reserved.
// - radio setup bit 3 picks 1 or 2 Mbps, resets to 2 Mbps.
// - radio setup bits 2:1 set transmit power, reset to 11.
// - radio setup bit 4 forces synthesizer lock, test only, resets 0.
`timescale 1ns/1ps
`include "radio_cfg_defs.svh"

module radio_link_config_registers
    import radio_cfg_pkg::*;
#(
    parameter int STEP_CYCLES = `RETR_STEP_US * `CLK_FREQ_MHZ
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    // serial port pins
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso_ff,
    output logic            miso_oe_ff,
    // packet engine handshake
    input  wire logic       tx_end,
    input  wire logic       ack_seen,
    input  wire logic       new_packet,
    output logic            retransmit_go_ff,
    output logic            give_up_ff,
    output logic [3:0]      retries_ff,
    // settings
    output radio_cfg_t      cfg_ff,
    output logic [4:0]      addr_byte_mask_ff
);
    localparam int TIMER_W = $clog2(16 * STEP_CYCLES + 1);

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic [2:0] s1_ff;          // {cs_n, sck, mosi}, first stage
    logic [2:0] s2_ff;
    logic       sck_d_ff;

    // pins are asynchronous, so two stages before any use
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s1_ff    <= 3'h4;
            s2_ff    <= 3'h4;
            sck_d_ff <= 1'b0;
        end else begin
            s1_ff    <= {cs_n, sck, mosi};
            s2_ff    <= s1_ff;
            sck_d_ff <= s2_ff[1];
        end
    end

    logic cs_act;
    logic sck_rise;
    logic sck_fall;
    assign cs_act   = ~s2_ff[2];
    assign sck_rise = s2_ff[1] & ~sck_d_ff;
    assign sck_fall = ~s2_ff[1] & sck_d_ff;

    // ****************************************************
    // register read mux and byte mask
    // ****************************************************
    // reserved bits read as zero, unmapped addresses read 8'h00
    function automatic logic [7:0] read_reg(input logic [4:0] a,
                                            input radio_cfg_t c);
        logic [7:0] d;
        d = 8'h00;
        if (a == `OFS_PIPE_EN) begin
            d = {3'h0, c.receive_pipe_enables};
        end else if (a == `OFS_ADDR_WIDTH) begin
            d = {6'h00, c.address_width_code};
        end else if (a == `OFS_RETR_SETUP) begin
            d = {c.retransmit_delay_code, c.retransmit_count_limit};
        end else if (a == `OFS_CHANNEL) begin
            d = {1'b0, c.channel_number};
        end else if (a == `OFS_RADIO_SETUP) begin
            d = {3'h0, c.pll_lock_force, c.air_rate_select,
                 c.output_power_code, 1'b0};
        end
        return d;
    endfunction

    // low bytes of each stored address stay valid for short widths
    function automatic logic [4:0] byte_mask(input logic [1:0] code);
        logic [4:0] m;
        case (code)
            2'h1:    m = 5'h07;
            2'h2:    m = 5'h0f;
            default: m = 5'h1f;
        endcase
        return m;
    endfunction

    // ****************************************************
    // serial slave and register file
    // ****************************************************
    spi_phase_t phase_ff, nxt_phase;
    logic [2:0] bit_cnt_ff, nxt_bit_cnt;
    logic [6:0] rx_sh_ff, nxt_rx_sh;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [7:0] tx_sh_ff, nxt_tx_sh;
    logic       nxt_miso;
    logic       nxt_miso_oe;
    radio_cfg_t nxt_cfg;
    logic [4:0] nxt_mask;
    logic [7:0] rx_byte;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [4:0] wr_addr;

    assign rx_byte = {rx_sh_ff, s2_ff[0]};
    assign wr_data = rx_byte;
    assign wr_addr = cmd_ff[4:0];

    // mode 0: sample on rising sck, shift out on falling sck
    always_comb begin
        nxt_phase   = phase_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_rx_sh   = rx_sh_ff;
        nxt_cmd     = cmd_ff;
        nxt_tx_sh   = tx_sh_ff;
        nxt_miso    = miso_ff;
        nxt_miso_oe = cs_act;
        nxt_cfg     = cfg_ff;
        wr_stb      = 1'b0;
        if (!cs_act) begin
            nxt_phase   = PH_CMD;
            nxt_bit_cnt = 3'h0;
            nxt_tx_sh   = 8'h00;
            nxt_miso    = 1'b0;
        end else if (sck_rise) begin
            nxt_rx_sh   = rx_byte[6:0];
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
                case (phase_ff)
                    PH_CMD: begin
                        nxt_cmd   = rx_byte;
                        nxt_phase = PH_DATA;
                        if (rx_byte[7:5] == `CMD_READ) begin
                            nxt_tx_sh = read_reg(rx_byte[4:0], cfg_ff);
                        end
                    end
                    PH_DATA: begin
                        // one data byte per frame; later bytes are ignored
                        wr_stb    = (cmd_ff[7:5] == `CMD_WRITE);
                        nxt_phase = PH_DONE;
                    end
                    default: ;
                endcase
            end
        end else if (sck_fall) begin
            nxt_miso  = tx_sh_ff[7];
            nxt_tx_sh = {tx_sh_ff[6:0], 1'b0};
        end
        // reserved bits are dropped on write
        if (wr_stb) begin
            if (wr_addr == `OFS_PIPE_EN) begin
                nxt_cfg.receive_pipe_enables = wr_data[4:0];
            end else if (wr_addr == `OFS_ADDR_WIDTH) begin
                // the illegal code leaves the width unchanged
                if (wr_data[1:0] != 2'h0) begin
                    nxt_cfg.address_width_code = wr_data[1:0];
                end
            end else if (wr_addr == `OFS_RETR_SETUP) begin
                nxt_cfg.retransmit_delay_code =
                    wr_data[`RETR_DELAY_LSB +: 4];
                nxt_cfg.retransmit_count_limit = wr_data[3:0];
            end else if (wr_addr == `OFS_CHANNEL) begin
                nxt_cfg.channel_number = wr_data[6:0];
            end else if (wr_addr == `OFS_RADIO_SETUP) begin
                nxt_cfg.pll_lock_force = wr_data[`RADIO_PLL_BIT];
                nxt_cfg.air_rate_select = wr_data[`RADIO_RATE_BIT];
                nxt_cfg.output_power_code =
                    wr_data[`RADIO_PWR_LSB +: 2];
            end
        end
        nxt_mask = byte_mask(nxt_cfg.address_width_code);
    end

    // register stage for the serial slave and the settings
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_ff   <= PH_CMD;
            bit_cnt_ff <= 3'h0;
            rx_sh_ff   <= 7'h00;
            cmd_ff     <= 8'h00;
            tx_sh_ff   <= 8'h00;
            miso_ff    <= 1'b0;
            miso_oe_ff <= 1'b0;
            cfg_ff     <= '{receive_pipe_enables:   `RST_PIPE_EN,
                            address_width_code:     `RST_ADDR_WIDTH,
                            retransmit_delay_code:  `RST_RETR_DELAY,
                            retransmit_count_limit: `RST_RETR_COUNT,
                            channel_number:         `RST_CHANNEL,
                            pll_lock_force:         `RST_PLL_FORCE,
                            air_rate_select:        `RST_AIR_RATE,
                            output_power_code:      `RST_POWER};
            addr_byte_mask_ff <= 5'h1f;
        end else begin
            phase_ff   <= nxt_phase;
            bit_cnt_ff <= nxt_bit_cnt;
            rx_sh_ff   <= nxt_rx_sh;
            cmd_ff     <= nxt_cmd;
            tx_sh_ff   <= nxt_tx_sh;
            miso_ff    <= nxt_miso;
            miso_oe_ff <= nxt_miso_oe;
            cfg_ff     <= nxt_cfg;
            addr_byte_mask_ff <= nxt_mask;
        end
    end

    // ****************************************************
    // retransmit delay and count
    // ****************************************************
    retr_state_t        rt_state_ff, nxt_rt_state;
    logic [TIMER_W-1:0] timer_ff, nxt_timer;
    logic [TIMER_W-1:0] delay_cycles;
    logic [3:0]         nxt_retries;
    logic               nxt_go;
    logic               nxt_give_up;

    // (code + 1) steps of 250 us
    assign delay_cycles = TIMER_W'((int'(cfg_ff.retransmit_delay_code) + 1)
                                   * STEP_CYCLES);

    // timer starts at the end of a transmission, not its start
    always_comb begin
        nxt_rt_state = rt_state_ff;
        nxt_timer    = timer_ff;
        nxt_retries  = new_packet ? 4'h0 : retries_ff;
        nxt_go       = 1'b0;
        nxt_give_up  = 1'b0;
        case (rt_state_ff)
            RT_IDLE: begin
                if (tx_end) begin
                    nxt_rt_state = RT_WAIT;
                    nxt_timer    = delay_cycles;
                end
            end
            RT_WAIT: begin
                if (ack_seen) begin
                    nxt_rt_state = RT_IDLE;
                    nxt_retries  = 4'h0;
                end else if (timer_ff <= TIMER_W'(1)) begin
                    nxt_rt_state = RT_IDLE;
                    // a limit of zero never retries
                    if (retries_ff < cfg_ff.retransmit_count_limit) begin
                        nxt_go      = 1'b1;
                        nxt_retries = retries_ff + 4'h1;
                    end else begin
                        nxt_give_up = 1'b1;
                        nxt_retries = 4'h0;
                    end
                end else begin
                    nxt_timer = timer_ff - TIMER_W'(1);
                end
            end
            default: nxt_rt_state = RT_IDLE;
        endcase
    end

    // register stage for the retransmit control
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rt_state_ff      <= RT_IDLE;
            timer_ff         <= '0;
            retries_ff       <= 4'h0;
            retransmit_go_ff <= 1'b0;
            give_up_ff       <= 1'b0;
        end else begin
            rt_state_ff      <= nxt_rt_state;
            timer_ff         <= nxt_timer;
            retries_ff       <= nxt_retries;
            retransmit_go_ff <= nxt_go;
            give_up_ff       <= nxt_give_up;
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    aw_legal_a: assert property (cfg_ff.address_width_code != 2'h0)
        else $error("address width code is zero");
    aw_hold_a: assert property (wr_stb && wr_addr == `OFS_ADDR_WIDTH
        && wr_data[1:0] == 2'h0 |=> $stable(cfg_ff.address_width_code))
        else $error("illegal width code was stored");
    byte_mask_a: assert property (##1 addr_byte_mask_ff ==
        byte_mask(cfg_ff.address_width_code))
        else $error("byte mask disagrees with width code");
    delay_load_a: assert property (rt_state_ff == RT_IDLE && tx_end
        |=> timer_ff == $past(delay_cycles))
        else $error("retransmit delay loaded wrong");
    retry_gap_a: assert property ($rose(rt_state_ff == RT_WAIT)
        |-> !retransmit_go_ff [*2])
        else $error("retry issued without waiting");
    retr_off_a: assert property (
        cfg_ff.retransmit_count_limit == 4'h0
        && rt_state_ff == RT_WAIT |=> !retransmit_go_ff)
        else $error("retry issued with retransmit disabled");
    retr_cap_a: assert property (retransmit_go_ff
        |-> retries_ff <= $past(cfg_ff.retransmit_count_limit))
        else $error("retry count above limit");
    chan_wr_a: assert property (wr_stb && wr_addr == `OFS_CHANNEL
        |=> cfg_ff.channel_number == $past(wr_data[6:0]))
        else $error("channel write lost");
    rate_wr_a: assert property (
        wr_stb && wr_addr == `OFS_RADIO_SETUP
        |=> cfg_ff.air_rate_select == $past(wr_data[3]))
        else $error("air rate write lost");
    power_wr_a: assert property (
        wr_stb && wr_addr == `OFS_RADIO_SETUP
        |=> cfg_ff.output_power_code == $past(wr_data[2:1]))
        else $error("power write lost");
    pll_wr_a: assert property (wr_stb && wr_addr == `OFS_RADIO_SETUP
        |=> cfg_ff.pll_lock_force == $past(wr_data[4]))
        else $error("lock force write lost");
    count_wr_a: assert property (
        wr_stb && wr_addr == `OFS_RETR_SETUP
        |=> cfg_ff.retransmit_count_limit == $past(wr_data[3:0]))
        else $error("retransmit count write lost");

    write_seen_c: cover property (wr_stb);
    retry_seen_c: cover property (retransmit_go_ff);
    give_up_seen_c: cover property (give_up_ff);
    ack_cancel_c: cover property (rt_state_ff == RT_WAIT && ack_seen);

endmodule // radio_link_config_registers

// >>> verif/spi_host_model.sv
// host-side serial master that reaches the configuration registers
`timescale 1ns/1ps

module spi_host_model (
    // clock
    input  wire logic clk_sys,
    // serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      mosi,
    input  wire logic miso
);
    // idle bus: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        mosi = 1'b0;
    end

    // each serial level stands four system clocks, above the sync lag
    task automatic hold4();
        repeat (4) @(negedge clk_sys);
    endtask

    // one frame: command byte then data byte, msb first, mode 0
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                        output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, dat};
        rd = 8'h00;
        @(negedge clk_sys);
        cs_n = 1'b0;
        hold4();
        for (int i = 15; i >= 0; i--) begin
            mosi = sh[i];
            hold4();
            sck = 1'b1;
            if (i < 8) rd[i] = miso; // a floating line reads z here
            hold4();
            sck = 1'b0;
        end
        hold4();
        cs_n = 1'b1;
        mosi = ~mosi; // the idle line is left at the inverse of the last bit sent
        hold4();
    endtask
endmodule // spi_host_model

// >>> verif/testbench.sv
// self-checking bench for the radio configuration register slice
`timescale 1ns/1ps
`include "radio_cfg_defs.svh"

module testbench;
    import radio_cfg_pkg::*;
    localparam int STEP = 4; // short delay step keeps the run brief
    logic       clk_sys, nrst, cs_n, sck, mosi, miso_ff, miso_oe_ff;
    logic       tx_end, ack_seen, new_packet, retransmit_go_ff, give_up_ff;
    logic [3:0] retries_ff;
    logic [4:0] addr_byte_mask_ff;
    radio_cfg_t cfg_ff;
    wire        miso_w = miso_oe_ff ? miso_ff : 1'bz;
    int         miscompares = 0;
    int         checks = 0;
    int         retries, ra;
    bit   [7:0] rm [2:6]; // register model
    localparam bit [7:0] WM [2:6] = '{8'h1f, 8'h03, 8'hff, 8'h7f, 8'h1e};

    radio_link_config_registers #(.STEP_CYCLES(STEP))
        radio_link_config_registers_i (.clk_sys, .nrst, .cs_n, .sck, .mosi,
        .miso_ff, .miso_oe_ff, .tx_end, .ack_seen, .new_packet,
        .retransmit_go_ff, .give_up_ff, .retries_ff, .cfg_ff,
        .addr_byte_mask_ff);
    spi_host_model spi_host_model_i (.clk_sys, .cs_n, .sck, .mosi,
        .miso(miso_w));

    // system clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // write with reserved bits zero; width code 00 leaves the old code
    task automatic wr(int a, bit [7:0] d);
        logic [7:0] rd;
        d &= WM[a];
        spi_host_model_i.xfer({`CMD_WRITE, a[4:0]}, d, rd);
        if (!(a == 3 && d == 8'h00)) rm[a] = d;
    endtask

    task automatic rdchk(int a);
        logic [7:0] rd;
        spi_host_model_i.xfer({`CMD_READ, a[4:0]}, 8'h00, rd);
        chk($sformatf("reg %0h", a),
            (a >= 2 && a <= 6) ? rm[a] : 8'h00, rd);
        // the data line must be released once the frame has closed
        chk("miso enable", 0, miso_oe_ff);
    endtask

    task automatic cmp_cfg();
        chk("cfg", {rm[2][4:0], rm[3][1:0], rm[4], rm[5][6:0], rm[6][4:1]},
            cfg_ff);
        chk("mask", (1 << (rm[3][1:0] + 2)) - 1, addr_byte_mask_ff);
    endtask

    // one transmission end; a second one inside the wait must be ignored
    task automatic retr_once(int d, int c);
        int n;
        tx_end = 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
            tx_end = (n == 3);
        end while (!(retransmit_go_ff | give_up_ff) && n < 200);
        chk("delay", (d + 1) * STEP + 1, n);
        if (retries < c) begin
            chk("go", 1, retransmit_go_ff);
            retries++;
        end else begin
            chk("give up", 1, give_up_ff);
            retries = 0;
        end
        chk("retries", retries, retries_ff);
        @(negedge clk_sys);
        chk("one pulse", 0, retransmit_go_ff | give_up_ff);
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
    endtask

    // hang guard, well above the expected run
    initial begin
        #(60000 * 100);
        miscompares++;
        $display("Error watchdog expected finish seen timeout");
        end_of_test();
    end

    //****************************************************************
    // main sequence
    //****************************************************************
    initial begin
        nrst = 1'b0;
        tx_end = 1'b0;
        ack_seen = 1'b0;
        new_packet = 1'b0;
        void'($urandom(23));
        rm = '{8'h03, 8'h03, 8'h03, 8'h02, 8'h0e};
        retries = 0;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmp_cfg();
        for (int a = 0; a < 8; a++) rdchk(a);
        rdchk(31);
        $display("test reset values done");
        for (int w = 0; w < 4; w++) begin
            wr(3, w);
            cmp_cfg();
        end
        wr(5, 8'hff);
        rdchk(5);
        $display("test width and channel done");
        for (int v = 0; v < 32; v += 2) begin
            wr(6, v);
            rdchk(6);
        end
        repeat (20) begin
            ra = 2 + $urandom_range(4);
            wr(ra, $urandom);
            rdchk(ra);
            cmp_cfg();
        end
        $display("test register traffic done");
        pulse(new_packet);
        retries = 0;
        foreach (WM[i]) begin
            ra = (i == 2) ? 8'h00 : (i == 3) ? 8'hf2 : (i == 4) ? 8'h3f : 8'h11;
            wr(4, ra);
            for (int k = 0; k <= ra[3:0]; k++) retr_once(ra[7:4], ra[3:0]);
        end
        $display("test retransmit timing done");
        wr(4, 8'h15);
        retr_once(1, 5);
        retr_once(1, 5);
        pulse(new_packet);
        retries = 0;
        chk("new packet", 0, retries_ff);
        retr_once(1, 5);
        tx_end = 1'b1;
        @(negedge clk_sys);
        tx_end = 1'b0;
        pulse(ack_seen);
        retries = 0;
        ra = 0;
        repeat (3 * STEP) begin
            @(negedge clk_sys);
            ra += retransmit_go_ff | give_up_ff;
        end
        chk("ack cancels", 0, ra);
        chk("ack clears", 0, retries_ff);
        $display("test acknowledge done");
        end_of_test();
    end
endmodule // testbench
